// ==== logic/tpu_trace_profile_unit.v ====
// trace capture, executed marks and machine-cycle counter for an
// in-circuit emulator watching a 4-bit core.
// assumes fetch strobes are one cycle wide and at least two cycles
// apart, and that the core's state inputs are valid with each strobe.
//
// Functional notes
// - 13-bit write pointer picks next slot of 8192-slot store, steps per entry.
// - pointer wraps past last slot, so newest entries overwrite oldest.
// - entry holds address, acc, ram fields, flags, banks, pairs, stacks, probes.
// - pending interrupt requests are stored in every trace entry.
// - one trace enable bit kept for each code memory address.
// - trace modes are disabled, free-running and triggered.
// - with enable-bit option on, only addresses whose bit is 1 are captured.
// - triggered: start/stop, start until break, or stop from emulation start.
// - trace captures only in real-time emulation, never in single step.
// - triggers act before execution: start captured, stop not.
// - triggers on second words or table data never fire.
// - enable bits are looked at only on first instruction words.
// - ram address and data fields change only on data memory writes.
// - carry, greater, zero and irq-enable flag changes land in the entry of the preceding instruction.
// - each table-read instruction fills two consecutive entries.
// - executed mark set to 1 for each address fetched in real time.
// - single-step execution leaves executed marks unchanged.
// - 24-bit counter adds machine cycles of each counted instruction.
// - counter has disabled, free-running and triggered modes like trace.
// - counting only in real-time emulation, never single step.
// - count triggers act before execution: start counted, stop not.
// - pointer wrap in real time raises full break if enabled; resume clears.
// - counter overflow in real time raises break if enabled; resume clears.
//
// The address map and the Avalon-MM interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "tpu_defs.vh"

module tpu_trace_profile_unit #(
    parameter PTR_W = 13,
    parameter CODE_AW = 16,
    parameter CNT_W = 24
) (
    // clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    // avalon-mm slave
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    output wire [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    // emulation state
    input wire realtime_run_in,
    input wire single_step_in,
    // fetch from the core
    input wire fetch_valid_in,
    input wire fetch_first_in,
    input wire [15:0] executed_instruction_address_in,
    input wire [1:0] machine_cycles_in,
    input wire table_read_in,
    // data memory writes
    input wire ram_write_in,
    input wire [11:0] data_memory_address_field_in,
    input wire [3:0] ram_data_in,
    // core state for trace entries
    input wire [3:0] accumulator_in,
    input wire [2:0] carry_greater_zero_flags_in,
    input wire global_irq_enable_in,
    input wire tune_request_flag_in,
    input wire [3:0] current_bank_value_in,
    input wire [3:0] extra_bank_value_in,
    input wire [7:0] first_index_pair_in,
    input wire [7:0] second_index_pair_in,
    input wire [4:0] call_stack_level_in,
    input wire [3:0] register_stack_level_in,
    input wire [3:0] probe_input_bits_in,
    input wire [3:0] irq_pending_in,
    // break requests
    output wire brk_trace_full_out,
    output wire brk_count_ovf_out
);

    localparam DEPTH = 1 << PTR_W;
    localparam CODE_DEPTH = 1 << CODE_AW;
    localparam [PTR_W-1:0] PTR_LAST = {PTR_W{1'b1}};
    localparam [PTR_W-1:0] PTR_ONE = {{(PTR_W-1){1'b0}}, 1'b1};

    // trigger step: start opens, stop closes before its own instruction
    function trig_on;
        input act;
        input start_hit;
        input stop_hit;
        begin
            trig_on = (act | start_hit) & ~stop_hit;
        end
    endfunction

    // trace store and per-address bitmaps
    reg [`TPU_ENTRY_W-1:0] trace_mem [0:DEPTH-1];
    reg trace_en_mem [0:CODE_DEPTH-1];
    reg executed_mark_bit_mem [0:CODE_DEPTH-1];

    // software-visible registers
    reg [`TPU_CTRL_W-1:0] ctrl_q;
    reg [15:0] tstart_q;
    reg [15:0] tstop_q;
    reg [15:0] cstart_q;
    reg [15:0] cstop_q;
    reg [PTR_W-1:0] tptr_q;
    reg [CNT_W-1:0] ccnt_q;
    reg [PTR_W-1:0] tidx_q;
    reg [CODE_AW-1:0] badr_q;

    // internal state
    reg run_q;
    reg tr_act_q;
    reg cc_act_q;
    reg [`TPU_ENTRY_W-1:0] pend_q;
    reg pend_v_q;
    reg dup_q;
    reg [11:0] ram_addr_q;
    reg [3:0] rdat_q;
    reg brk_full_q;
    reg brk_ovf_q;
    reg wait_q;
    reg [31:0] rdata_q;
    reg [31:0] rdata_d;

    // bus handshake: one wait cycle, access completes when wait is low
    wire bus_req = avs_read_in | avs_write_in;
    wire bus_acc = bus_req & ~wait_q;
    wire bus_wr = avs_write_in & ~wait_q;

    // run means real-time emulation, single step excluded
    wire run = realtime_run_in & ~single_step_in;
    wire run_rise = run & ~run_q;
    wire fetch_rt = fetch_valid_in & run;
    wire first = fetch_rt & fetch_first_in;
    wire [15:0] fa = executed_instruction_address_in;

    // trace trigger decode, only ever evaluated on first words
    wire t_start_hit = ctrl_q[`TPU_CTRL_TSTART] & (fa == tstart_q);
    wire t_stop_hit = ctrl_q[`TPU_CTRL_TSTOP] & (fa == tstop_q);
    // stop-only arms tracing at the start of emulation
    wire t_base = run_rise ?
        (ctrl_q[`TPU_CTRL_TSTOP] & ~ctrl_q[`TPU_CTRL_TSTART]) :
        tr_act_q;
    wire t_trig = trig_on(t_base, t_start_hit, t_stop_hit);
    wire [1:0] tmode = ctrl_q[`TPU_CTRL_TMODE];
    wire t_on = (tmode == `TPU_MODE_FREE) |
        ((tmode == `TPU_MODE_TRIG) & t_trig);
    wire te_ok = ~ctrl_q[`TPU_CTRL_TEBIT] |
        trace_en_mem[fa[CODE_AW-1:0]];
    wire capture = first & t_on & te_ok;

    // count trigger decode, same scheme as trace
    wire c_start_hit = ctrl_q[`TPU_CTRL_CSTART] & (fa == cstart_q);
    wire c_stop_hit = ctrl_q[`TPU_CTRL_CSTOP] & (fa == cstop_q);
    wire c_base = run_rise ?
        (ctrl_q[`TPU_CTRL_CSTOP] & ~ctrl_q[`TPU_CTRL_CSTART]) :
        cc_act_q;
    wire c_trig = trig_on(c_base, c_start_hit, c_stop_hit);
    wire [1:0] cmode = ctrl_q[`TPU_CTRL_CMODE];
    wire c_on = (cmode == `TPU_MODE_FREE) |
        ((cmode == `TPU_MODE_TRIG) & c_trig);
    wire count = first & c_on;

    // counter sum with carry for overflow detection
    wire [CNT_W:0] ccnt_sum = {1'b0, ccnt_q} +
        {{(CNT_W-1){1'b0}}, machine_cycles_in};

    // ram fields follow the latest data memory write only
    wire [11:0] ram_addr_cur = ram_write_in ?
        data_memory_address_field_in : ram_addr_q;
    wire [3:0] rdat_cur = ram_write_in ? ram_data_in : rdat_q;

    // entry for the instruction now fetched
    wire [`TPU_ENTRY_W-1:0] cur_entry = {
        1'b0,
        irq_pending_in,
        probe_input_bits_in,
        register_stack_level_in,
        call_stack_level_in,
        second_index_pair_in,
        first_index_pair_in,
        extra_bank_value_in,
        current_bank_value_in,
        tune_request_flag_in,
        global_irq_enable_in,
        carry_greater_zero_flags_in,
        rdat_cur,
        ram_addr_cur,
        accumulator_in,
        fa};

    // the held entry is written once the next instruction shows the
    // flags, so a carry, greater, zero or irq-enable change lands one entry early as the core sees it
    wire flush = pend_v_q & (first | dup_q | ~run);
    wire [`TPU_ENTRY_W-1:0] wr_entry = {
        pend_q[`TPU_E_TOP_KEEP],
        global_irq_enable_in,
        carry_greater_zero_flags_in,
        pend_q[`TPU_E_LOW_KEEP]};
    wire wrap = flush & (tptr_q == PTR_LAST);

    // entry currently selected for host readback
    wire [`TPU_ENTRY_W-1:0] rd_entry = trace_mem[tidx_q];

    // trace store write port, no reset on memory
    always @(posedge clk_sys_in) begin
        if (flush) begin
            trace_mem[tptr_q] <= wr_entry;
        end
    end

    // bitmaps: host write first, a real-time fetch mark overrides it
    always @(posedge clk_sys_in) begin
        if (bus_wr && avs_address_in == `TPU_REG_BDAT) begin
            trace_en_mem[badr_q] <= avs_writedata_in[`TPU_BDAT_TEN];
            executed_mark_bit_mem[badr_q] <=
                avs_writedata_in[`TPU_BDAT_MARK];
        end
        if (fetch_rt) begin
            executed_mark_bit_mem[fa[CODE_AW-1:0]] <= 1'b1;
        end
    end

    // run edge, trigger state and ram field holding
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            run_q <= 1'b0;
            tr_act_q <= 1'b0;
            cc_act_q <= 1'b0;
            ram_addr_q <= 12'h000;
            rdat_q <= 4'h0;
        end else begin
            run_q <= run;
            if (first) begin
                tr_act_q <= t_trig;
                cc_act_q <= c_trig;
            end else if (run_rise) begin
                tr_act_q <= t_base;
                cc_act_q <= c_base;
            end
            if (ram_write_in) begin
                ram_addr_q <= data_memory_address_field_in;
                rdat_q <= ram_data_in;
            end
        end
    end

    // held entry and the second copy of a table read
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            pend_q <= {`TPU_ENTRY_W{1'b0}};
            pend_v_q <= 1'b0;
            dup_q <= 1'b0;
        end else begin
            if (capture) begin
                pend_q <= cur_entry;
                pend_v_q <= 1'b1;
                dup_q <= table_read_in;
            end else if (flush && dup_q) begin
                // top bit marks the second entry of a table read
                pend_q <= {1'b1, pend_q[`TPU_E_REST]};
                dup_q <= 1'b0;
            end else if (flush) begin
                pend_v_q <= 1'b0;
            end
        end
    end

    // pointer and counter: core advances, host reloads only when stopped
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            tptr_q <= {PTR_W{1'b0}};
            ccnt_q <= {CNT_W{1'b0}};
        end else begin
            if (flush) begin
                // natural wrap at the last slot
                tptr_q <= tptr_q + PTR_ONE;
            end else if (bus_wr && !run &&
                         avs_address_in == `TPU_REG_TPTR) begin
                tptr_q <= avs_writedata_in[PTR_W-1:0];
            end
            if (count) begin
                ccnt_q <= ccnt_sum[CNT_W-1:0];
            end else if (bus_wr && !run &&
                         avs_address_in == `TPU_REG_CCNT) begin
                ccnt_q <= avs_writedata_in[CNT_W-1:0];
            end
        end
    end

    // break requests: resume clears, a set in that cycle still wins
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            brk_full_q <= 1'b0;
            brk_ovf_q <= 1'b0;
        end else begin
            if (run_rise) begin
                brk_full_q <= 1'b0;
                brk_ovf_q <= 1'b0;
            end
            if (wrap && run && ctrl_q[`TPU_CTRL_BRKFULL]) begin
                brk_full_q <= 1'b1;
            end
            if (count && ccnt_sum[CNT_W] && ctrl_q[`TPU_CTRL_BRKOVF]) begin
                brk_ovf_q <= 1'b1;
            end
        end
    end

    // plain host registers
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            ctrl_q <= `TPU_CTRL_RST;
            tstart_q <= `TPU_ADDR_RST;
            tstop_q <= `TPU_ADDR_RST;
            cstart_q <= `TPU_ADDR_RST;
            cstop_q <= `TPU_ADDR_RST;
            tidx_q <= {PTR_W{1'b0}};
            badr_q <= {CODE_AW{1'b0}};
        end else if (bus_wr) begin
            case (avs_address_in)
                `TPU_REG_CTRL: begin
                    ctrl_q <= avs_writedata_in[`TPU_CTRL_W-1:0];
                end
                `TPU_REG_TSTART: begin
                    tstart_q <= avs_writedata_in[15:0];
                end
                `TPU_REG_TSTOP: begin
                    tstop_q <= avs_writedata_in[15:0];
                end
                `TPU_REG_CSTART: begin
                    cstart_q <= avs_writedata_in[15:0];
                end
                `TPU_REG_CSTOP: begin
                    cstop_q <= avs_writedata_in[15:0];
                end
                `TPU_REG_TIDX: begin
                    tidx_q <= avs_writedata_in[PTR_W-1:0];
                end
                `TPU_REG_BADR: begin
                    badr_q <= avs_writedata_in[CODE_AW-1:0];
                end
                default: begin
                    // read-only, unmapped, or written in another block (pointer, counter, bitmaps): ignored here
                end
            endcase
        end
    end

    // read mux; unmapped words read as zero
    always @* begin
        rdata_d = `TPU_ZERO32;
        case (avs_address_in)
            `TPU_REG_CTRL: rdata_d[`TPU_CTRL_W-1:0] = ctrl_q;
            `TPU_REG_STAT: rdata_d[5:0] = {pend_v_q, run, cc_act_q,
                tr_act_q, brk_ovf_q, brk_full_q};
            `TPU_REG_TSTART: rdata_d[15:0] = tstart_q;
            `TPU_REG_TSTOP: rdata_d[15:0] = tstop_q;
            `TPU_REG_CSTART: rdata_d[15:0] = cstart_q;
            `TPU_REG_CSTOP: rdata_d[15:0] = cstop_q;
            `TPU_REG_TPTR: rdata_d[PTR_W-1:0] = tptr_q;
            `TPU_REG_CCNT: rdata_d[CNT_W-1:0] = ccnt_q;
            `TPU_REG_TIDX: rdata_d[PTR_W-1:0] = tidx_q;
            `TPU_REG_TDAT0: rdata_d = rd_entry[31:0];
            `TPU_REG_TDAT1: rdata_d = rd_entry[`TPU_E_W1];
            `TPU_REG_TDAT2: rdata_d = {`TPU_E_W2_PAD, rd_entry[`TPU_E_W2]};
            `TPU_REG_BADR: rdata_d[CODE_AW-1:0] = badr_q;
            `TPU_REG_BDAT: rdata_d[1:0] = {executed_mark_bit_mem[badr_q],
                trace_en_mem[badr_q]};
            default: rdata_d = `TPU_ZERO32;
        endcase
    end

    // bus answer: wait low for exactly one cycle after a request is seen
    always @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            wait_q <= 1'b1;
            rdata_q <= `TPU_ZERO32;
        end else begin
            if (bus_acc) begin
                wait_q <= 1'b1;
            end else if (bus_req) begin
                wait_q <= 1'b0;
                if (avs_read_in) begin
                    rdata_q <= rdata_d;
                end
            end
        end
    end

    // outputs straight from flip-flops
    assign avs_readdata_out = rdata_q;
    assign avs_waitrequest_out = wait_q;
    assign brk_trace_full_out = brk_full_q;
    assign brk_count_ovf_out = brk_ovf_q;

endmodule // tpu_trace_profile_unit

// ==== logic/tpu_defs.vh ====
// constants for the trace and profiling unit: register map, control
// field positions, modes, trace entry layout and reset values.
// assumes a word-addressed avalon-mm slave port with 32-bit data.
`ifndef TPU_DEFS_VH
`define TPU_DEFS_VH

// register word offsets
`define TPU_REG_CTRL 4'h0
`define TPU_REG_STAT 4'h1
`define TPU_REG_TSTART 4'h2
`define TPU_REG_TSTOP 4'h3
`define TPU_REG_CSTART 4'h4
`define TPU_REG_CSTOP 4'h5
`define TPU_REG_TPTR 4'h6
`define TPU_REG_CCNT 4'h7
`define TPU_REG_TIDX 4'h8
`define TPU_REG_TDAT0 4'h9
`define TPU_REG_TDAT1 4'hA
`define TPU_REG_TDAT2 4'hB
`define TPU_REG_BADR 4'hC
`define TPU_REG_BDAT 4'hD

// control register fields
`define TPU_CTRL_W 11
`define TPU_CTRL_RST 11'h000
`define TPU_CTRL_TMODE 1:0
`define TPU_CTRL_TEBIT 2
`define TPU_CTRL_TSTART 3
`define TPU_CTRL_TSTOP 4
`define TPU_CTRL_CMODE 6:5
`define TPU_CTRL_CSTART 7
`define TPU_CTRL_CSTOP 8
`define TPU_CTRL_BRKFULL 9
`define TPU_CTRL_BRKOVF 10

// trace and count modes
`define TPU_MODE_OFF 2'h0
`define TPU_MODE_FREE 2'h1
`define TPU_MODE_TRIG 2'h2

// bitmap data register fields
`define TPU_BDAT_TEN 0
`define TPU_BDAT_MARK 1

// trace entry layout
`define TPU_ENTRY_W 83
`define TPU_IRQ_W 4
`define TPU_E_FLAG_LSB 36
`define TPU_E_TOP_KEEP 82:40
`define TPU_E_LOW_KEEP 35:0
`define TPU_E_REST 81:0
`define TPU_E_W1 63:32
`define TPU_E_W2 82:64
`define TPU_E_W2_PAD 13'h0000

// misc reset and fill values
`define TPU_ZERO32 32'h0000_0000
`define TPU_ADDR_RST 16'h0000

`endif

// ==== tb/tpu_trace_monitor.sv ====
// checker for the trace unit: bus handshake, readback and break outputs.
// assumes it is bound to tpu_trace_profile_unit and sees only its ports.
`timescale 1ns/1ps

module tpu_trace_monitor (
    // clock and reset
    input wire clk_sys_in,
    input wire reset_in,
    // register bus
    input wire [3:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_readdata_out,
    input wire avs_waitrequest_out,
    // emulation, fetch and breaks
    input wire realtime_run_in,
    input wire fetch_valid_in,
    input wire brk_trace_full_out,
    input wire brk_count_ovf_out
);
    default clocking mon_clk @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);

    // every access gets exactly one cycle of waitrequest low
    chk_wait_low: assert property ((avs_read_in || avs_write_in) &&
        avs_waitrequest_out |=> !avs_waitrequest_out)
        else $error("waitrequest stayed high on a request");
    chk_wait_pulse: assert property (!avs_waitrequest_out |=>
        avs_waitrequest_out) else $error("waitrequest low too long");
    // unmapped place 0xE reads as zero, and data holds between reads
    chk_rd_unmapped: assert property (avs_read_in && avs_waitrequest_out &&
        avs_address_in == 4'hE |=> avs_readdata_out == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_rd_hold: assert property (!avs_read_in |=>
        $stable(avs_readdata_out)) else $error("read data moved");
    // break requests stand while emulation is stopped
    chk_full_hold: assert property (brk_trace_full_out &&
        !realtime_run_in |=> brk_trace_full_out)
        else $error("full break dropped while stopped");
    chk_ovf_hold: assert property (brk_count_ovf_out &&
        !realtime_run_in |=> brk_count_ovf_out)
        else $error("overflow break dropped while stopped");
    // resume clears them; a few quiet cycles allow for registering
    chk_full_clear: assert property ($rose(realtime_run_in) &&
        !fetch_valid_in ##1 !fetch_valid_in [*3] |-> !brk_trace_full_out)
        else $error("full break not cleared on resume");
    chk_ovf_clear: assert property ($rose(realtime_run_in) &&
        !fetch_valid_in ##1 !fetch_valid_in [*3] |-> !brk_count_ovf_out)
        else $error("overflow break not cleared on resume");
    // counting only happens in real time, so overflow needs run
    chk_ovf_cause: assert property ($rose(brk_count_ovf_out) |->
        $past(realtime_run_in) || $past(realtime_run_in, 2))
        else $error("overflow break without real-time run");
endmodule // tpu_trace_monitor

bind tpu_trace_profile_unit tpu_trace_monitor u_mon (
    .clk_sys_in(clk_sys_in), .reset_in(reset_in),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .realtime_run_in(realtime_run_in), .fetch_valid_in(fetch_valid_in),
    .brk_trace_full_out(brk_trace_full_out),
    .brk_count_ovf_out(brk_count_ovf_out));

// ==== tb/tpu_core_model.sv ====
// model of the emulated core: fetch strobes with address and cycle count.
// assumes the bench calls fetch() and owns run and single step.
`timescale 1ns/1ps

module tpu_core_model (
    // clock
    input wire clk_sys_in,
    // fetch strobe and its qualifiers
    output reg fetch_valid_out,
    output reg fetch_first_out,
    output reg [15:0] addr_out,
    output reg [1:0] cycles_out,
    output reg table_read_out
);
    // quiet at time zero
    initial begin
        fetch_valid_out = 1'b0;
        fetch_first_out = 1'b0;
        addr_out = 16'hFFFF;
        cycles_out = 2'h1;
        table_read_out = 1'b0;
    end

    // one-cycle strobe, then idle; the idle address is inverted so a
    // stale value can never pass for a real fetch
    task automatic fetch(input [15:0] a, input first, input [1:0] cyc,
        input tbl);
        @(posedge clk_sys_in);
        fetch_valid_out <= 1'b1;
        fetch_first_out <= first;
        addr_out <= a;
        cycles_out <= cyc;
        table_read_out <= tbl;
        @(posedge clk_sys_in);
        fetch_valid_out <= 1'b0;
        addr_out <= ~a;
        repeat (2) @(posedge clk_sys_in);
    endtask
endmodule // tpu_core_model

// ==== tb/tb_top.sv ====
// bench for the trace unit: register tasks and emulation sequences.
// assumes a 16-slot store and 256-word code space to reach wrap quickly.
`timescale 1ns/1ps
`include "tpu_defs.vh"

module tb_top;
    reg clk_sys_in, reset_in, run, step, avs_read, avs_write, ram_wr;
    reg [3:0] avs_address;
    reg [31:0] avs_writedata, rd;
    wire [31:0] avs_readdata;
    wire avs_waitrequest, brk_full, brk_ovf, fv, ff, tr;
    wire [15:0] fa;
    wire [1:0] mc;
    integer num_errors, n_compared;

    tpu_core_model core (.clk_sys_in(clk_sys_in), .fetch_valid_out(fv),
        .fetch_first_out(ff), .addr_out(fa), .cycles_out(mc),
        .table_read_out(tr));
    // core state is derived from the fetch address
    tpu_trace_profile_unit #(.PTR_W(4), .CODE_AW(8), .CNT_W(24)) dut (
        .clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .avs_address_in(avs_address), .avs_read_in(avs_read),
        .avs_write_in(avs_write), .avs_writedata_in(avs_writedata),
        .avs_readdata_out(avs_readdata),
        .avs_waitrequest_out(avs_waitrequest),
        .realtime_run_in(run), .single_step_in(step),
        .fetch_valid_in(fv), .fetch_first_in(ff),
        .executed_instruction_address_in(fa), .machine_cycles_in(mc),
        .table_read_in(tr), .ram_write_in(ram_wr),
        .data_memory_address_field_in(fa[11:0]), .ram_data_in(fa[3:0]),
        .accumulator_in(fa[3:0]), .carry_greater_zero_flags_in(fa[2:0]),
        .global_irq_enable_in(fa[0]), .tune_request_flag_in(fa[1]),
        .current_bank_value_in(fa[3:0]), .extra_bank_value_in(fa[7:4]),
        .first_index_pair_in(fa[7:0]), .second_index_pair_in(fa[15:8]),
        .call_stack_level_in(fa[4:0]), .register_stack_level_in(fa[3:0]),
        .probe_input_bits_in(fa[11:8]), .irq_pending_in(fa[7:4]),
        .brk_trace_full_out(brk_full), .brk_count_ovf_out(brk_ovf));

    // 100 MHz clock
    initial begin
        clk_sys_in = 1'b0;
        forever #5 clk_sys_in = ~clk_sys_in;
    end

    task report_and_stop;
        if (num_errors == 0 && n_compared > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task check(input [31:0] seen, input [31:0] exp);
        n_compared = n_compared + 1;
        if (seen !== exp) begin
            num_errors = num_errors + 1;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one bus access held until waitrequest is sampled low
    task bus(input wr, input [3:0] a, input [31:0] d);
        @(posedge clk_sys_in);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        @(posedge clk_sys_in);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys_in);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task rd_chk(input [3:0] a, input [31:0] exp);
        bus(1'b0, a, 32'h0000_0000);
        check(rd, exp);
    endtask

    // program, run n fetches (cycles 1,2,3 repeating), then stop
    task run_seq(input [31:0] ctrl, input [15:0] t1, input [15:0] t2,
        input [31:0] p0, input [31:0] c0, input [15:0] base,
        input integer n, input [7:0] smask, input [7:0] tmask, input ss);
        integer i;
        bus(1'b1, `TPU_REG_CTRL, ctrl);
        bus(1'b1, `TPU_REG_TSTART, {16'h0000, t1});
        bus(1'b1, `TPU_REG_TSTOP, {16'h0000, t2});
        bus(1'b1, `TPU_REG_CSTART, {16'h0000, t1});
        bus(1'b1, `TPU_REG_CSTOP, {16'h0000, t2});
        bus(1'b1, `TPU_REG_TPTR, p0);
        bus(1'b1, `TPU_REG_CCNT, c0);
        step <= ss;
        run <= 1'b1;
        repeat (5) @(posedge clk_sys_in);
        for (i = 0; i < n; i = i + 1)
            core.fetch(base + i[15:0], !smask[i], 2'(i % 3 + 1), tmask[i]);
        @(posedge clk_sys_in);
        run <= 1'b0;
        step <= 1'b0;
        repeat (4) @(posedge clk_sys_in);
    endtask

    task chk_pc(input [31:0] p, input [31:0] c);
        rd_chk(`TPU_REG_TPTR, p);
        rd_chk(`TPU_REG_CCNT, c);
    endtask

    // a hang ends the run as a failure
    initial begin
        repeat (30000) @(posedge clk_sys_in);
        num_errors = num_errors + 1;
        report_and_stop;
    end

    initial begin
        {reset_in, run, step, avs_read, avs_write, ram_wr} = 6'h20;
        avs_address = 4'h0;
        avs_writedata = 32'h0000_0000;
        num_errors = 0;
        n_compared = 0;
        repeat (8) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        // reset values and an unmapped place
        rd_chk(`TPU_REG_CTRL, 32'h0000_0000);
        chk_pc(32'h0, 32'h0);
        rd_chk(4'hE, 32'h0000_0000);
        // free trace and count, first fetch a table read
        run_seq(32'h21, 0, 0, 0, 0, 16'h10, 6, 8'h00, 8'h01, 1'b0);
        chk_pc(32'h7, 32'd12);
        bus(1'b1, `TPU_REG_TIDX, 32'h0);
        rd_chk(`TPU_REG_TDAT0, 32'h0000_0010);
        bus(1'b0, `TPU_REG_TDAT2, 32'h0);
        check(rd & 32'h0007_C000, 32'h0000_4000);
        bus(1'b1, `TPU_REG_TIDX, 32'h1);
        bus(1'b0, `TPU_REG_TDAT2, 32'h0);
        check(rd & 32'h0004_0000, 32'h0004_0000);
        bus(1'b1, `TPU_REG_BADR, 32'h10);
        bus(1'b0, `TPU_REG_BDAT, 32'h0);
        check(rd & 32'h2, 32'h2);
        // triggered: start and stop, start only, stop only
        run_seq(32'h1DA, 16'h21, 16'h24, 0, 0, 16'h20, 6, 0, 0, 1'b0);
        chk_pc(32'h3, 32'd6);
        bus(1'b1, `TPU_REG_TIDX, 32'h0);
        bus(1'b0, `TPU_REG_TDAT0, 32'h0);
        check(rd & 32'h0000_FFFF, 32'h0000_0021);
        // flags of entry 0x21 are those shown at the 0x22 strobe
        bus(1'b0, `TPU_REG_TDAT1, 32'h0);
        check(rd & 32'h0000_00F0, 32'h0000_0020);
        run_seq(32'hCA, 16'h22, 0, 0, 0, 16'h20, 6, 0, 0, 1'b0);
        chk_pc(32'h4, 32'd9);
        run_seq(32'h152, 0, 16'h23, 0, 0, 16'h20, 6, 0, 0, 1'b0);
        chk_pc(32'h3, 32'd6);
        // a start address seen only as a second word never fires
        run_seq(32'hCA, 16'h22, 0, 0, 0, 16'h20, 6, 8'h04, 0, 1'b0);
        chk_pc(32'h0, 32'h0);
        // one data memory write while idle at address 0xFFDA
        @(posedge clk_sys_in);
        ram_wr <= 1'b1;
        @(posedge clk_sys_in);
        ram_wr <= 1'b0;
        // enable-bit option: only 0x40 is marked for capture
        bus(1'b1, `TPU_REG_BADR, 32'h40);
        bus(1'b1, `TPU_REG_BDAT, 32'h1);
        bus(1'b1, `TPU_REG_BADR, 32'h41);
        bus(1'b1, `TPU_REG_BDAT, 32'h0);
        run_seq(32'h25, 0, 0, 0, 0, 16'h40, 2, 0, 0, 1'b0);
        chk_pc(32'h1, 32'd3);
        // ram fields repeat the last write in later entries
        bus(1'b1, `TPU_REG_TIDX, 32'h0);
        rd_chk(`TPU_REG_TDAT0, 32'hFDA0_0040);
        bus(1'b0, `TPU_REG_TDAT1, 32'h0);
        check(rd & 32'h0000_000F, 32'h0000_000A);
        // single step captures, counts and marks nothing
        bus(1'b1, `TPU_REG_BADR, 32'h60);
        bus(1'b1, `TPU_REG_BDAT, 32'h0);
        run_seq(32'h21, 0, 0, 32'h5, 32'h7, 16'h60, 1, 0, 0, 1'b1);
        chk_pc(32'h5, 32'h7);
        bus(1'b1, `TPU_REG_BADR, 32'h60);
        bus(1'b0, `TPU_REG_BDAT, 32'h0);
        check(rd & 32'h2, 32'h0);
        // pointer wrap and counter overflow with both breaks on
        run_seq(32'h621, 0, 0, 32'hE, 32'hFF_FFFE, 16'h50, 3, 0, 0, 1'b0);
        chk_pc(32'h1, 32'h4);
        check({31'h0, brk_full}, 32'h1);
        check({31'h0, brk_ovf}, 32'h1);
        repeat (20) @(posedge clk_sys_in);
        chk_pc(32'h1, 32'h4);
        // disabled modes; resuming clears both breaks
        run_seq(32'h0, 0, 0, 0, 0, 16'h70, 2, 0, 0, 1'b0);
        chk_pc(32'h0, 32'h0);
        check({30'h0, brk_full, brk_ovf}, 32'h0);
        report_and_stop;
    end
endmodule // tb_top
